// ===== bench/aivl_chk.sv
// Checker on the ports of the converter interrupt block.
// Assumes a bind to aivl_top; enables are shadowed from control writes.
`timescale 1ns/1ps
module aivl_chk
  import aivl_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       conv_done_evt_i,
  input wire logic       range_watch_evt_i,
  input wire logic       irq_req_o,
  input wire logic [2:0] irq_priority_o,
  input wire logic [7:0] irq_vector_o
);
  // ==========================================================
  // Enable shadows
  // Shadow enables, same timing as the control register
  logic ce_r, re_r, ce_nxt, re_nxt, wc, wv;
  assign wc = reg_wr_i && (reg_addr_i == AIVL_ADDR_CONTROL);
  assign wv = reg_wr_i && (reg_addr_i == AIVL_ADDR_VECTOR);
  always_comb begin
    ce_nxt = wc ? reg_wdata_i[5] : ce_r;
    re_nxt = wc ? reg_wdata_i[4] : re_r;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ce_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      ce_r <= ce_nxt;
      re_r <= re_nxt;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rst; !$past(nrst_i) |-> irq_vector_o == 8'h02 && !irq_req_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_vrd; reg_addr_i == AIVL_ADDR_VECTOR |=> !reg_rdata_o[0]; endproperty
  a_vrd: assert property (p_vrd) else $error("vector bit 0 set");
  property p_prio; wc ##1 !wc |=> irq_priority_o == $past(reg_wdata_i[2:0], 2); endproperty
  a_prio: assert property (p_prio) else $error("bad priority");
  property p_base; wv ##1 !wv |=> irq_vector_o[7:2] == $past(reg_wdata_i[7:2], 2); endproperty
  a_base: assert property (p_base) else $error("bad vector base");
  property p_range; range_watch_evt_i && re_r && !reg_wr_i ##1 !reg_wr_i
    |=> irq_req_o && !irq_vector_o[1]; endproperty
  a_range: assert property (p_range) else $error("watchdog not served");
  property p_conv; conv_done_evt_i && ce_r && !re_r && !reg_wr_i ##1 !reg_wr_i
    |=> irq_req_o && irq_vector_o[1]; endproperty
  a_conv: assert property (p_conv) else $error("conversion not served");
  property p_soft; wc && reg_wdata_i[7] && reg_wdata_i[5] ##1 !reg_wr_i |=> irq_req_o; endproperty
  a_soft: assert property (p_soft) else $error("software set ignored");
  property p_clr; wc && reg_wdata_i[7:6] == 2'b00 && !conv_done_evt_i && !range_watch_evt_i
    |=> ##1 !irq_req_o; endproperty
  a_clr: assert property (p_clr) else $error("request kept");
  c_lo: cover property (irq_req_o && !irq_vector_o[1]);
  c_hi: cover property (irq_req_o && irq_vector_o[1]);
  c_fall: cover property ($fell(irq_req_o));
endmodule : aivl_chk

// ===== bench/aivl_core_model.sv
// Core-side model: takes the converter vector when a request rises.
// Assumes the request is a plain level and needs no acknowledge.
`timescale 1ns/1ps
module aivl_core_model (
  input  wire logic       core_clk_i,  // Core clock
  input  wire logic       nrst_i,      // Async reset, active low
  input  wire logic       req_i,       // Converter request level
  input  wire logic [7:0] vec_i,       // Vector offered with it
  output logic      [7:0] served_vec_o // Vector taken at last rise
);
  // ==========================================================
  // Vector fetch
  // Entry only on a fresh request, like a real vector fetch
  logic       req_r;
  logic [7:0] vec_nxt;
  always_comb begin
    vec_nxt = (req_i && !req_r) ? vec_i : served_vec_o;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_r        <= 1'b0;
      served_vec_o <= 8'h00;
    end else begin
      req_r        <= req_i;
      served_vec_o <= vec_nxt;
    end
  end
endmodule : aivl_core_model

// ===== bench/aivl_top_bench.sv
// Bench for the converter interrupt block, with core model and checker.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module aivl_top_bench;
  import aivl_pkg::*;
  logic       core_clk_i, nrst_i, reg_wr_i, conv_done_evt_i, range_watch_evt_i, irq_req_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, irq_vector_o, served_vec;
  logic [2:0] irq_priority_o;
  int         n_errors = 0, compares = 0, cycles = 0;
  aivl_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .conv_done_evt_i(conv_done_evt_i), .range_watch_evt_i(range_watch_evt_i),
    .irq_req_o(irq_req_o), .irq_priority_o(irq_priority_o), .irq_vector_o(irq_vector_o));
  aivl_core_model core (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(irq_req_o),
    .vec_i(irq_vector_o), .served_vec_o(served_vec));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Hang guard; the run needs well under 200 cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Strobe stays up so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
  endtask : wr
  task automatic idle(input int n);
    reg_wr_i = 1'b0;
    repeat (n) @(negedge core_clk_i);
  endtask : idle
  // Read data is registered, so it is looked at one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_wr_i = 1'b0;
    reg_addr_i = a;
    @(negedge core_clk_i);
    chk(reg_rdata_o, e);
  endtask : rd
  task automatic pulse(input logic c, input logic r);
    conv_done_evt_i = c;
    range_watch_evt_i = r;
    @(negedge core_clk_i);
    conv_done_evt_i = 1'b0;
    range_watch_evt_i = 1'b0;
  endtask : pulse
  task automatic t_regs;
    rd(AIVL_ADDR_VECTOR, 8'h02);
    rd(8'h10, 8'h00);
    wr(AIVL_ADDR_CONTROL, 8'h35);
    wr(AIVL_ADDR_VECTOR, 8'hab);
    idle(1);
    chk({5'h00, irq_priority_o}, 8'h05);
    wr(8'h10, 8'hff); // Unmapped write, must leave both registers alone
    rd(AIVL_ADDR_CONTROL, 8'h3d);
    rd(AIVL_ADDR_VECTOR, 8'haa);
    $display("register test done");
  endtask : t_regs
  task automatic t_both;
    wr(AIVL_ADDR_CONTROL, 8'h02);
    idle(1);
    pulse(1'b1, 1'b1);
    idle(2);
    chk({7'h00, irq_req_o}, 8'h00);
    rd(AIVL_ADDR_CONTROL, 8'hca);
    wr(AIVL_ADDR_CONTROL, 8'h30);
    idle(1);
    pulse(1'b1, 1'b1);
    idle(1);
    chk(irq_vector_o, 8'ha8);
    rd(AIVL_ADDR_VECTOR, 8'ha8);
    wr(AIVL_ADDR_CONTROL, 8'hb0);
    idle(1);
    chk(served_vec, 8'ha8);
    chk({irq_vector_o[7:1], irq_req_o}, 8'hab);
    wr(AIVL_ADDR_CONTROL, 8'h30);
    idle(1);
    chk({7'h00, irq_req_o}, 8'h00);
    $display("mask and priority test done");
  endtask : t_both
  task automatic t_soft;
    wr(AIVL_ADDR_CONTROL, 8'ha0);
    idle(1);
    chk({irq_vector_o[7:1], irq_req_o}, 8'hab);
    wr(AIVL_ADDR_CONTROL, 8'h20);
    idle(1);
    pulse(1'b1, 1'b0);
    idle(1);
    chk({irq_vector_o[7:1], irq_req_o}, 8'hab);
    $display("software request test done");
  endtask : t_soft
  // Mid-run reset with a request live; vector must fall back to its reset form
  task automatic t_reset;
    nrst_i = 1'b0;
    idle(2);
    nrst_i = 1'b1;
    rd(AIVL_ADDR_VECTOR, 8'h02);
    chk({irq_vector_o[7:1], irq_req_o}, 8'h02);
    $display("reset test done");
  endtask : t_reset
  initial begin
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    conv_done_evt_i = 1'b0;
    range_watch_evt_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_regs();
    t_both();
    t_soft();
    t_reset();
    summarize();
  end
endmodule : aivl_top_bench
bind aivl_top aivl_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .conv_done_evt_i(conv_done_evt_i),
  .range_watch_evt_i(range_watch_evt_i), .irq_req_o(irq_req_o),
  .irq_priority_o(irq_priority_o), .irq_vector_o(irq_vector_o));

// ===== logic/aivl_arb_if.sv
// Carrier between the register block and the source arbiter.
// Assumes both ends share core_clk_i; all signals are plain levels.
`timescale 1ns/1ps
interface aivl_arb_if;
  logic conv_flag;   // conv_done_flag
  logic range_flag;  // range_watch_flag
  logic conv_en;     // conv_done_irq_enable
  logic range_en;    // range_watch_irq_enable
  logic req;         // Any unmasked source
  logic wsel;        // Chosen source word

  modport regs (output conv_flag, range_flag, conv_en, range_en, input req, wsel);
  modport arb  (input conv_flag, range_flag, conv_en, range_en, output req, wsel);
endinterface : aivl_arb_if

// ===== logic/aivl_arbiter.sv
// Source arbiter: masks the two event flags and picks one source.
// Assumes flags and enables arrive as registered levels.
`timescale 1ns/1ps
module aivl_arbiter
  import aivl_pkg::*;
(
  aivl_arb_if.arb  arb_if
);

  import aivl_pkg::*;

  // ==========================================================
  // Masking and selection
  logic conv_live;   // Unmasked conversion-done source
  logic range_live;  // Unmasked out-of-range source

  // Gate each flag with its enable; pure logic, no state kept here
  always_comb begin
    conv_live  = arb_if.conv_flag & arb_if.conv_en;
    range_live = arb_if.range_flag & arb_if.range_en;
    arb_if.req = conv_live | range_live;
    // Watchdog wins a tie; conversion flag stays set, so it is only deferred
    if (range_live) begin
      arb_if.wsel = AIVL_WSEL_RANGE;
    end else if (conv_live) begin
      arb_if.wsel = AIVL_WSEL_CONV;
    end else begin
      arb_if.wsel = AIVL_WSEL_CONV;                     // Idle default, as reset
    end
  end

endmodule : aivl_arbiter

// ===== logic/aivl_pkg.sv
// Shared constants for the converter interrupt request and vector logic.
// Assumes an 8-bit register file addressed by the CPU core.
package aivl_pkg;

  // ==========================================================
  // Register file addresses
  localparam logic [7:0] AIVL_ADDR_CONTROL = 8'hfe;  // converter_irq_control
  localparam logic [7:0] AIVL_ADDR_VECTOR  = 8'hff;  // converter_irq_vector

  // ==========================================================
  // Control register fields
  localparam int AIVL_CTL_CONV_FLAG_BIT  = 7;  // conv_done_flag
  localparam int AIVL_CTL_RANGE_FLAG_BIT = 6;  // range_watch_flag
  localparam int AIVL_CTL_CONV_EN_BIT    = 5;  // conv_done_irq_enable
  localparam int AIVL_CTL_RANGE_EN_BIT   = 4;  // range_watch_irq_enable
  localparam int AIVL_CTL_RSVD_BIT       = 3;  // Reserved, reads as one
  localparam int AIVL_CTL_PRIO_MSB       = 2;  // irq_priority_level
  localparam int AIVL_CTL_PRIO_LSB       = 0;

  // ==========================================================
  // Vector register fields
  localparam int AIVL_VEC_BASE_MSB = 7;  // Service block base
  localparam int AIVL_VEC_BASE_LSB = 2;
  localparam int AIVL_VEC_WSEL_BIT = 1;  // source_word_select
  localparam int AIVL_VEC_ZERO_BIT = 0;  // Always zero

  // ==========================================================
  // Reset values
  localparam logic [7:0] AIVL_CONTROL_RESET = 8'h0f;
  localparam logic [7:0] AIVL_VECTOR_RESET  = 8'h02;
  localparam logic       AIVL_WSEL_RANGE    = 1'b0;  // Lower word
  localparam logic       AIVL_WSEL_CONV     = 1'b1;  // Upper word

endpackage : aivl_pkg

// ===== logic/aivl_top.sv
// Converter interrupt request and vector logic, register side and core side.
// Assumes a register file port synchronous to core_clk_i, one access a cycle.
`timescale 1ns/1ps
module aivl_top
  import aivl_pkg::*;
(
  input  wire logic       core_clk_i,          // Internal clock, 40 MHz
  input  wire logic       nrst_i,              // Async reset, active low
  input  wire logic [7:0] reg_addr_i,          // Register file address
  input  wire logic       reg_wr_i,            // Write strobe, one cycle
  input  wire logic [7:0] reg_wdata_i,         // Write data
  output logic      [7:0] reg_rdata_o,         // Read data, one cycle late
  input  wire logic       conv_done_evt_i,     // Group of conversions done
  input  wire logic       range_watch_evt_i,   // Monitored input out of window
  output logic            irq_req_o,           // Request toward the core
  output logic      [2:0] irq_priority_o,      // Priority for core arbitration
  output logic      [7:0] irq_vector_o         // Vector for the chosen source
);

  import aivl_pkg::*;

  // ==========================================================
  // State
  logic       conv_flag_r;    // conv_done_flag
  logic       conv_flag_nxt;
  logic       range_flag_r;   // range_watch_flag
  logic       range_flag_nxt;
  logic       conv_en_r;      // conv_done_irq_enable
  logic       conv_en_nxt;
  logic       range_en_r;     // range_watch_irq_enable
  logic       range_en_nxt;
  logic [2:0] prio_r;         // irq_priority_level
  logic [2:0] prio_nxt;
  logic [5:0] vec_base_r;     // Service block base
  logic [5:0] vec_base_nxt;
  logic       wsel_r;         // source_word_select, hardware owned
  logic       wsel_nxt;
  logic [7:0] rdata_r;        // Registered read data
  logic [7:0] rdata_nxt;
  logic       req_r;          // Registered request
  logic       req_nxt;
  logic [2:0] prio_out_r;     // Registered priority toward the core
  logic [2:0] prio_out_nxt;
  logic [7:0] vec_out_r;      // Registered vector toward the core
  logic [7:0] vec_out_nxt;

  // ==========================================================
  // Decode helpers
  logic       wr_control;     // Write hits the control register
  logic       wr_vector;      // Write hits the vector register
  logic [7:0] control_view;   // Control register as read
  logic [7:0] vector_view;    // Vector register as read

  // ==========================================================
  // Arbiter link
  aivl_arb_if arb_if ();

  assign arb_if.conv_flag  = conv_flag_r;
  assign arb_if.range_flag = range_flag_r;
  assign arb_if.conv_en    = conv_en_r;
  assign arb_if.range_en   = range_en_r;

  // Masking and source choice live in the arbiter
  aivl_arbiter u_arbiter (
    .arb_if (arb_if.arb)
  );

  // ==========================================================
  // Address decode
  always_comb begin
    wr_control = 1'b0;
    wr_vector  = 1'b0;
    if (reg_wr_i && (reg_addr_i == AIVL_ADDR_CONTROL)) begin
      wr_control = 1'b1;                         // Control write
    end else if (reg_wr_i && (reg_addr_i == AIVL_ADDR_VECTOR)) begin
      wr_vector = 1'b1;                          // Vector write
    end
  end

  // ==========================================================
  // Read views
  always_comb begin
    control_view = '0;
    control_view[AIVL_CTL_CONV_FLAG_BIT]  = conv_flag_r;
    control_view[AIVL_CTL_RANGE_FLAG_BIT] = range_flag_r;
    control_view[AIVL_CTL_CONV_EN_BIT]    = conv_en_r;
    control_view[AIVL_CTL_RANGE_EN_BIT]   = range_en_r;
    control_view[AIVL_CTL_RSVD_BIT]       = AIVL_CONTROL_RESET[AIVL_CTL_RSVD_BIT];
    control_view[AIVL_CTL_PRIO_MSB:AIVL_CTL_PRIO_LSB] = prio_r;
    vector_view = '0;
    vector_view[AIVL_VEC_BASE_MSB:AIVL_VEC_BASE_LSB] = vec_base_r;
    vector_view[AIVL_VEC_WSEL_BIT] = wsel_r;
    vector_view[AIVL_VEC_ZERO_BIT] = 1'b0;
  end

  // ==========================================================
  // Event flags
  // Hardware set beats a software clear in the same cycle, so no event is lost
  always_comb begin
    conv_flag_nxt  = conv_flag_r;
    range_flag_nxt = range_flag_r;
    if (wr_control) begin
      // Writing one sets the flag as a software request
      conv_flag_nxt  = reg_wdata_i[AIVL_CTL_CONV_FLAG_BIT];
      range_flag_nxt = reg_wdata_i[AIVL_CTL_RANGE_FLAG_BIT];
    end
    if (conv_done_evt_i) begin
      conv_flag_nxt = 1'b1;
    end
    if (range_watch_evt_i) begin
      range_flag_nxt = 1'b1;
    end
  end

  // Flag registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_flag_r  <= AIVL_CONTROL_RESET[AIVL_CTL_CONV_FLAG_BIT];
      range_flag_r <= AIVL_CONTROL_RESET[AIVL_CTL_RANGE_FLAG_BIT];
    end else begin
      conv_flag_r  <= conv_flag_nxt;
      range_flag_r <= range_flag_nxt;
    end
  end

  // ==========================================================
  // Enables and priority
  always_comb begin
    conv_en_nxt  = conv_en_r;
    range_en_nxt = range_en_r;
    prio_nxt     = prio_r;
    if (wr_control) begin
      conv_en_nxt  = reg_wdata_i[AIVL_CTL_CONV_EN_BIT];
      range_en_nxt = reg_wdata_i[AIVL_CTL_RANGE_EN_BIT];
      prio_nxt     = reg_wdata_i[AIVL_CTL_PRIO_MSB:AIVL_CTL_PRIO_LSB];
    end
  end

  // Enable and priority registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_en_r  <= AIVL_CONTROL_RESET[AIVL_CTL_CONV_EN_BIT];
      range_en_r <= AIVL_CONTROL_RESET[AIVL_CTL_RANGE_EN_BIT];
      prio_r     <= AIVL_CONTROL_RESET[AIVL_CTL_PRIO_MSB:AIVL_CTL_PRIO_LSB];
    end else begin
      conv_en_r  <= conv_en_nxt;
      range_en_r <= range_en_nxt;
      prio_r     <= prio_nxt;
    end
  end

  // ==========================================================
  // Vector register
  // Word select ignores software; it takes the arbiter's choice while a request is live and holds it otherwise
  always_comb begin
    vec_base_nxt = vec_base_r;
    if (wr_vector) begin
      vec_base_nxt = reg_wdata_i[AIVL_VEC_BASE_MSB:AIVL_VEC_BASE_LSB];
    end
    wsel_nxt = wsel_r;
    if (arb_if.req) begin
      wsel_nxt = arb_if.wsel;
    end
  end

  // Vector registers; base has no documented reset, cleared for determinism
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vec_base_r <= AIVL_VECTOR_RESET[AIVL_VEC_BASE_MSB:AIVL_VEC_BASE_LSB];
      wsel_r     <= AIVL_VECTOR_RESET[AIVL_VEC_WSEL_BIT];
    end else begin
      vec_base_r <= vec_base_nxt;
      wsel_r     <= wsel_nxt;
    end
  end

  // ==========================================================
  // Read data
  // Unmapped addresses return zero
  always_comb begin
    if (reg_addr_i == AIVL_ADDR_CONTROL) begin
      rdata_nxt = control_view;
    end else if (reg_addr_i == AIVL_ADDR_VECTOR) begin
      rdata_nxt = vector_view;
    end else begin
      rdata_nxt = '0;
    end
  end

  // Read data register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Core-side request
  // Vector is formed from the arbiter choice directly, so it agrees with req
  always_comb begin
    req_nxt      = arb_if.req;
    prio_out_nxt = prio_r;
    vec_out_nxt  = {vec_base_r, arb_if.wsel, 1'b0};
  end

  // Core-side output registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_r      <= 1'b0;
      prio_out_r <= AIVL_CONTROL_RESET[AIVL_CTL_PRIO_MSB:AIVL_CTL_PRIO_LSB];
      vec_out_r  <= AIVL_VECTOR_RESET;
    end else begin
      req_r      <= req_nxt;
      prio_out_r <= prio_out_nxt;
      vec_out_r  <= vec_out_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o    = rdata_r;
  assign irq_req_o      = req_r;
  assign irq_priority_o = prio_out_r;
  assign irq_vector_o   = vec_out_r;

endmodule : aivl_top
